// ===== src/lstis_regs.svh
`ifndef LSTIS_REGS_SVH
`define LSTIS_REGS_SVH

// Register byte addresses
`define LSTIS_TAP_SNAPSHOT_OFS 16'hF060
`define LSTIS_SEL_OFS          16'hF064
`define LSTIS_IRQ_STATUS_OFS   16'hF068
`define LSTIS_IRQ_MASK_OFS     16'hF06C

// Reset values
`define LSTIS_SEL_RST          16'h0630
`define LSTIS_CHAIN_RST        15'h0000
`define LSTIS_IRQ_MASK_RST     3'h0

// Writable bits of the selection register
`define LSTIS_SEL_WMASK        16'h0777

// Field positions
`define LSTIS_IRQ0_SEL_LSB     0
`define LSTIS_IRQ1_SEL_LSB     4
`define LSTIS_IRQ2_SEL_LSB     8
`define LSTIS_SEL_W            3

// Chain layout: bit 0 toggles at 16 kHz, tap_128hz is bit 7, tap_1hz bit 14
`define LSTIS_CHAIN_W          15
`define LSTIS_TAP_LSB          7
`define LSTIS_TAP_W            8
`define LSTIS_LINES            3

// Bus responses
`define LSTIS_RESP_OKAY        2'h0
`define LSTIS_RESP_SLVERR      2'h2

`endif

// ===== src/lstis_pkg.sv
`default_nettype none

package lstis_pkg;

    typedef struct packed {
        logic [4:0] rsv_hi;
        logic [2:0] irq2_tap_sel;
        logic       rsv1;
        logic [2:0] irq1_tap_sel;
        logic       rsv0;
        logic [2:0] irq0_tap_sel;
    } lstis_sel_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } lstis_addr_hold_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic [3:0]  strb;
    } lstis_data_hold_type;

endpackage : lstis_pkg

`default_nettype wire

// ===== src/lstis_core.sv
// Overview of operation
// RQ1: Three 3-bit tap selectors sit at bits 2..0, 6..4, 10..8.
// RQ2: Code 0 picks 128 Hz tap, each higher code halves, 7 picks 1 Hz.
// RQ3: Selection register resets to 0630: 128 Hz, 16 Hz, 2 Hz.
// RQ4: Changing a selection may raise a request at once on a falling edge.
// RQ5: After reset the chain counts from zero on low-speed clock falling edges.
// RQ6: Each line requests on every falling edge of its selected tap.
// RQ7: Reading the snapshot register returns current 128 Hz..1 Hz tap levels.
// RQ8: Software reads snapshot twice and accepts only matching values.
// RQ9: Any snapshot write resets the chain, forcing all taps to zero.
// RQ10: A selected tap dropping through that reset also raises a request.
// RQ11: Software masks requests, writes snapshot, then clears caused requests.
// RQ12: Request flag is set one cycle after the edge; software waits.
// RQ13: Snapshot bit 0 is 128 Hz tap, up to 1 Hz tap at bit 7.
// RQ14: A snapshot write clears it whatever data is written.
// RQ15: Chain derives taps by successive halving of the low-speed clock.
// RQ16: Each detected falling edge gives one single-cycle request pulse.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none

`include "lstis_regs.svh"

module lstis_core #(
    parameter int ADDR_W = 16
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              low_speed_clock,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output var  logic [2:0]        irq_req,
    output var  logic              irq
);

    // Bus state
    lstis_pkg::lstis_addr_hold_type aw_reg;
    lstis_pkg::lstis_addr_hold_type aw_next;
    lstis_pkg::lstis_data_hold_type w_reg;
    lstis_pkg::lstis_data_hold_type w_next;
    logic        awready_reg;
    logic        awready_next;
    logic        wready_reg;
    logic        wready_next;
    logic        bvalid_reg;
    logic        bvalid_next;
    logic [1:0]  bresp_reg;
    logic [1:0]  bresp_next;
    logic        arready_reg;
    logic        arready_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_reg;
    logic [1:0]  rresp_next;

    // Block state
    lstis_pkg::lstis_sel_type sel_reg;
    lstis_pkg::lstis_sel_type sel_next;
    logic [`LSTIS_CHAIN_W-1:0] chain_reg;
    logic [`LSTIS_CHAIN_W-1:0] chain_next;
    logic                      low_speed_clock_prev_reg;
    logic [`LSTIS_LINES-1:0]   tap_prev_reg;
    logic [`LSTIS_LINES-1:0]   tap_cur;
    logic [`LSTIS_LINES-1:0]   fall;
    logic [`LSTIS_LINES-1:0]   irq_req_reg;
    logic [`LSTIS_LINES-1:0]   status_reg;
    logic [`LSTIS_LINES-1:0]   status_next;
    logic [`LSTIS_LINES-1:0]   mask_reg;
    logic [`LSTIS_LINES-1:0]   mask_next;
    logic                      irq_reg;
    logic                      irq_next;

    logic                    commit;
    logic                    snap_wr;
    logic [`LSTIS_LINES-1:0] w1c;
    logic [`LSTIS_TAP_W-1:0] taps;
    logic                    ls_fall;
    logic [15:0]             sel_wdata;

    assign taps    = chain_reg[`LSTIS_TAP_LSB +: `LSTIS_TAP_W]; // [RQ13] [RQ7]
    assign ls_fall = low_speed_clock_prev_reg & ~low_speed_clock;
    // Write commits only once both halves are held and no response is pending
    assign commit  = aw_reg.valid & w_reg.valid & ~bvalid_reg;

    // Selected tap per line
    always_comb begin
        tap_cur[0] = taps[sel_reg.irq0_tap_sel]; // [RQ2]
        tap_cur[1] = taps[sel_reg.irq1_tap_sel]; // [RQ2]
        tap_cur[2] = taps[sel_reg.irq2_tap_sel]; // [RQ2]
        // Previous level is of whichever tap was selected, so a new selection counts
        fall = tap_prev_reg & ~tap_cur; // [RQ6] [RQ4] [RQ10]
    end

    // Bus channel logic
    always_comb begin
        aw_next      = aw_reg;
        w_next       = w_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        snap_wr      = 1'b0;
        w1c          = '0;
        sel_wdata    = sel_reg;
        mask_next    = mask_reg;
        sel_next     = sel_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_next.valid = 1'b1;
            aw_next.addr  = s_axi_awaddr[15:0];
        end
        if (s_axi_wvalid && wready_reg) begin
            w_next.valid = 1'b1;
            w_next.data  = s_axi_wdata;
            w_next.strb  = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (commit) begin
            aw_next.valid = 1'b0;
            w_next.valid  = 1'b0;
            bvalid_next   = 1'b1;
            bresp_next    = `LSTIS_RESP_OKAY;
            case (aw_reg.addr)
                `LSTIS_TAP_SNAPSHOT_OFS: begin
                    snap_wr = 1'b1; // [RQ9] [RQ14]
                end
                `LSTIS_SEL_OFS: begin
                    if (w_reg.strb[0]) begin
                        sel_wdata[7:0] = w_reg.data[7:0];
                    end
                    if (w_reg.strb[1]) begin
                        sel_wdata[15:8] = w_reg.data[15:8];
                    end
                    sel_next = sel_wdata & `LSTIS_SEL_WMASK; // [RQ1]
                end
                `LSTIS_IRQ_STATUS_OFS: begin
                    if (w_reg.strb[0]) begin
                        w1c = w_reg.data[`LSTIS_LINES-1:0];
                    end
                end
                `LSTIS_IRQ_MASK_OFS: begin
                    if (w_reg.strb[0]) begin
                        mask_next = w_reg.data[`LSTIS_LINES-1:0];
                    end
                end
                default: begin
                    bresp_next = `LSTIS_RESP_SLVERR;
                end
            endcase
        end
        awready_next = ~aw_next.valid;
        wready_next  = ~w_next.valid;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = `LSTIS_RESP_OKAY;
            rdata_next  = '0;
            case (s_axi_araddr[15:0])
                `LSTIS_TAP_SNAPSHOT_OFS: begin
                    rdata_next[`LSTIS_TAP_W-1:0] = taps; // [RQ7]
                end
                `LSTIS_SEL_OFS: begin
                    rdata_next[15:0] = sel_reg;
                end
                `LSTIS_IRQ_STATUS_OFS: begin
                    rdata_next[`LSTIS_LINES-1:0] = status_reg;
                end
                `LSTIS_IRQ_MASK_OFS: begin
                    rdata_next[`LSTIS_LINES-1:0] = mask_reg;
                end
                default: begin
                    rresp_next = `LSTIS_RESP_SLVERR;
                end
            endcase
        end
        arready_next = ~rvalid_next;
    end

    // Divider chain and request logic
    always_comb begin
        chain_next = chain_reg;
        if (snap_wr) begin
            // Clear wins over a coincident count so every tap reads zero after it
            chain_next = `LSTIS_CHAIN_RST; // [RQ9]
        end else if (ls_fall) begin
            chain_next = chain_reg + `LSTIS_CHAIN_W'(1); // [RQ5] [RQ15]
        end
        // A new edge wins over a clear in the same cycle
        status_next = (status_reg & ~w1c) | fall;
        irq_next    = |(status_next & mask_next);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg         <= '0;
            w_reg          <= '0;
            awready_reg    <= 1'b0;
            wready_reg     <= 1'b0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= `LSTIS_RESP_OKAY;
            arready_reg    <= 1'b0;
            rvalid_reg     <= 1'b0;
            rdata_reg      <= '0;
            rresp_reg      <= `LSTIS_RESP_OKAY;
            sel_reg        <= `LSTIS_SEL_RST; // [RQ3]
            chain_reg      <= `LSTIS_CHAIN_RST; // [RQ5]
            low_speed_clock_prev_reg <= 1'b0;
            tap_prev_reg   <= '0;
            irq_req_reg    <= '0;
            status_reg     <= '0;
            mask_reg       <= `LSTIS_IRQ_MASK_RST;
            irq_reg        <= 1'b0;
        end else begin
            aw_reg         <= aw_next;
            w_reg          <= w_next;
            awready_reg    <= awready_next;
            wready_reg     <= wready_next;
            bvalid_reg     <= bvalid_next;
            bresp_reg      <= bresp_next;
            arready_reg    <= arready_next;
            rvalid_reg     <= rvalid_next;
            rdata_reg      <= rdata_next;
            rresp_reg      <= rresp_next;
            sel_reg        <= sel_next;
            chain_reg      <= chain_next;
            low_speed_clock_prev_reg <= low_speed_clock;
            tap_prev_reg   <= tap_cur;
            irq_req_reg    <= fall; // [RQ16] [RQ12]
            status_reg     <= status_next;
            mask_reg       <= mask_next;
            irq_reg        <= irq_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq_req       = irq_req_reg;
    assign irq           = irq_reg;

endmodule : lstis_core

`default_nettype wire

// ===== tb/lstis_far_model.sv
`default_nettype none

module lstis_far_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic [2:0] irq_req,
    output var  logic       low_speed_clock = 1'b0,
    output var  int         fall_cnt = 0,
    output var  int         irq_cnt [3]
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands still between bursts so snapshot reads stay stable
    always @(posedge aclk) begin
        if (!aresetn) begin
            low_speed_clock <= 1'b0;
            fall_cnt <= 0;
            irq_cnt <= '{0, 0, 0};
        end else begin
            if (run) begin
                low_speed_clock <= ~low_speed_clock;
                fall_cnt <= fall_cnt + int'(low_speed_clock);
            end
            for (int i = 0; i < 3; i++) begin
                irq_cnt[i] <= irq_cnt[i] + int'(irq_req[i]);
            end
        end
    end
endmodule : lstis_far_model

`default_nettype wire

// ===== tb/lstis_core_assertions.sv
`default_nettype none
`include "lstis_regs.svh"

module lstis_core_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [15:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [2:0]  irq_req,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] ar_last_reg;

    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ar_last_reg <= s_axi_araddr;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_REQ_PULSE: assert property (irq_req != 3'h0 |=>
        (irq_req & $past(irq_req)) == 3'h0) else $error("Request pulse too long");
    AST_IRQ_RISE: assert property ($rose(irq) |-> irq_req != 3'h0 || $rose(s_axi_bvalid))
        else $error("Interrupt rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("Interrupt fell without a write");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data not held");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("Write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response not held");
    AST_SEL_BITS: assert property (s_axi_rvalid && ar_last_reg == `LSTIS_SEL_OFS |->
        (s_axi_rdata & 32'hFFFF_F888) == 32'h0) else $error("Selection spare bits set");
    AST_SNAP_BITS: assert property (s_axi_rvalid &&
        ar_last_reg == `LSTIS_TAP_SNAPSHOT_OFS |-> s_axi_rdata[31:8] == 24'h0 &&
        s_axi_rresp == 2'h0) else $error("Snapshot read bad");

    COV_REQ: cover property (irq_req[0]);
    COV_IRQ: cover property ($rose(irq));
    COV_WR: cover property ($rose(s_axi_bvalid));
endmodule : lstis_core_checker

bind lstis_core lstis_core_checker u_lstis_core_checker (.*);

`default_nettype wire

// ===== tb/lstis_core_bench.sv
`default_nettype none
`include "lstis_regs.svh"

module lstis_core_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        run = 1'b0;
    logic        low_speed_clock;
    logic [15:0] s_axi_awaddr = 16'h0;
    logic [15:0] s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, v;
    logic [2:0]  irq_req;
    int          fall_cnt;
    int          irq_cnt [3];
    int          error_cnt = 0;
    int          num_checks = 0;

    lstis_core u_lstis_core (.*);
    lstis_far_model u_lstis_far_model (.*);

    always #5 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Late ready keeps the response waiting a cycle, so its hold is exercised
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rc(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rc

    // A read that straddles a count is repeated until two agree
    task automatic snap;
        logic [31:0] e;
        do begin
            rd(`LSTIS_TAP_SNAPSHOT_OFS, v);
            rd(`LSTIS_TAP_SNAPSHOT_OFS, e);
        end while (v !== e);
    endtask : snap

    task automatic lsc(input int n);
        run <= 1'b1;
        wait (fall_cnt == n);
        run <= 1'b0;
        repeat (4) @(posedge aclk);
        snap();
    endtask : lsc

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    initial begin
        #50us;
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(`LSTIS_SEL_OFS, 32'h630);
        rc(`LSTIS_IRQ_MASK_OFS, 32'h0);
        snap();
        chk(v, 32'h0);
        wr(`LSTIS_IRQ_MASK_OFS, 32'h7);
        chk({30'h0, rsp}, {30'h0, `LSTIS_RESP_OKAY});
        lsc(128);
        chk(v, 32'h1);
        lsc(256);
        chk(v, 32'h2);
        chk(32'(irq_cnt[0]), 32'h1);
        rc(`LSTIS_IRQ_STATUS_OFS, 32'h1);
        wr(`LSTIS_SEL_OFS, 32'hFFFF_FFFF);
        rc(`LSTIS_SEL_OFS, 32'h777);
        // Only code 1 picks a high tap now, so only it falls on return to 0
        for (int k = 0; k < 8; k++) begin
            wr(`LSTIS_SEL_OFS, 32'h111 * k);
            rc(`LSTIS_SEL_OFS, 32'h111 * k);
            wr(`LSTIS_SEL_OFS, 32'h0);
            repeat (3) @(posedge aclk);
            chk(32'(irq_cnt[2]), (k > 0) ? 32'h1 : 32'h0);
        end
        chk({irq_cnt[0][15:0], irq_cnt[1][15:0]}, 32'h0002_0001);
        chk({31'h0, irq}, 32'h1);
        wr(`LSTIS_IRQ_STATUS_OFS, 32'h7);
        chk({31'h0, irq}, 32'h0);
        wr(`LSTIS_SEL_OFS, 32'h111);
        wr(`LSTIS_IRQ_MASK_OFS, 32'h0);
        wr(`LSTIS_TAP_SNAPSHOT_OFS, 32'hFF);
        repeat (2) @(posedge aclk);
        chk(32'(irq_cnt[1]), 32'h2);
        chk({31'h0, irq}, 32'h0);
        snap();
        chk(v, 32'h0);
        rc(`LSTIS_IRQ_STATUS_OFS, 32'h7);
        wr(`LSTIS_IRQ_STATUS_OFS, 32'h7);
        rc(`LSTIS_IRQ_STATUS_OFS, 32'h0);
        rd(16'hF070, v);
        chk({22'h0, rsp, v[7:0]}, {22'h0, `LSTIS_RESP_SLVERR, 8'h0});
        wr(16'hF070, 32'h7);
        chk({30'h0, rsp}, {30'h0, `LSTIS_RESP_SLVERR});
        rc(`LSTIS_SEL_OFS, 32'h111);
        wrap_up();
    end
endmodule : lstis_core_bench

`default_nettype wire
